// ===== hw/mps_defs.vh
// Purpose : Constants for the motion program sequencer
// Assumes : 100 MHz clk, 32-bit program words
// Notes   : Opcode in bits 31:28, operand in bits 23:0
`ifndef MPS_DEFS_VH
`define MPS_DEFS_VH

// ----------------------------------------------------------------
// Step word layout
// ----------------------------------------------------------------
`define MPS_OP_HI        31
`define MPS_OP_LO        28
`define MPS_ARG_HI       23
`define MPS_ARG_LO       0
`define MPS_ADDR_W       6
`define MPS_DEPTH        64

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define MPS_OP_STOP      4'h0
`define MPS_OP_SPEED     4'h1
`define MPS_OP_ACC       4'h2
`define MPS_OP_DEC       4'h3
`define MPS_OP_ACCDEC    4'h4
`define MPS_OP_SCURVE    4'h5
`define MPS_OP_ABS       4'h6
`define MPS_OP_ABS_CONT  4'h7
`define MPS_OP_INC       4'h8
`define MPS_OP_INC_CONT  4'h9
`define MPS_OP_OUT_ON    4'hA
`define MPS_OP_OUT_OFF   4'hB
`define MPS_OP_TRIP      4'hC
`define MPS_OP_LATCH     4'hD
`define MPS_OP_ITP       4'hE
`define MPS_OP_SYNC      4'hF

// ----------------------------------------------------------------
// Travel family and timing
// ----------------------------------------------------------------
`define MPS_FAM_NONE     2'h0
`define MPS_FAM_ABS      2'h1
`define MPS_FAM_INC      2'h2
`define MPS_TICK_NS      10000000
`define MPS_CLK_NS       10
`define MPS_TICK_CYC     ((`MPS_TICK_NS) / (`MPS_CLK_NS))
`define MPS_TICK_W       20
// Last count of the 10 ms divider, sized to the counter
`define MPS_TICK_LAST    20'hF423F
`define MPS_ONT_W        16
`define MPS_POS_W        32

`endif

// ===== hw/mps_prog_mem.v
// Purpose : Program store, one write port, registered read
// Assumes : Single clock
// Notes   : Loaded by the host while the sequencer is idle
`timescale 1ns/1ps
`include "mps_defs.vh"

module mps_prog_mem
(
  input  wire                    clk,
  input  wire                    wr_en,
  input  wire [`MPS_ADDR_W-1:0]  wr_addr,
  input  wire [31:0]             wr_data,
  input  wire [`MPS_ADDR_W-1:0]  rd_addr,
  output reg  [31:0]             rd_data
);

  reg [31:0] mem [0:`MPS_DEPTH-1];

  always @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end

endmodule // mps_prog_mem

// ===== hw/mps_sequencer.v
// Purpose : Runs stored motion programs, one step at a time
// Assumes : Pin inputs asynchronous; motion generator on clk
// Notes   : Travel goes out as a one-cycle request with settings
//
// How it works
// R01 - Sync, output, trip, latch and interrupt steps run while travel still outputs.
// R02 - Speed step takes effect during any of the four travel commands.
// R03 - Time-constant steps only feed non-continuous travel; continuous travel ignores them.
// R04 - Output-on with nonzero on-time holds program until that time elapses.
// R05 - Interrupt step skipped if remaining small, stopped or decelerating.
// R06 - Parameter default applies until a program step overrides it, until stop.
// R07 - Travel and trip values scaled by power-of-ten unit exponent.
// R08 - Speed and time constants kept across program starts.
// R09 - S-curve constant reloaded from parameter at every program start.
// R10 - After S-curve step, parameter no longer affects motion.
// R11 - Programs never mix absolute with incremental continuous forms.
// R12 - Absolute continuous after absolute runs blended, no stop.
// R13 - Incremental continuous after incremental runs blended, no stop.
// R14 - Continuous step speed applies from preceding step's deceleration start.
// R15 - Continuous step reuses time constants of preceding same-type travel.
// R16 - Forbidden mix stops program and raises program error.
`timescale 1ns/1ps
`include "mps_defs.vh"

module mps_sequencer
(
  input  wire                    clk,
  input  wire                    srst,
  input  wire                    load_en,
  input  wire [`MPS_ADDR_W-1:0]  load_addr,
  input  wire [31:0]             load_data,
  input  wire                    start_pin,
  input  wire                    latch_pin,
  input  wire [23:0]             s_curve_time_param,
  input  wire [1:0]              position_unit_param,
  input  wire [`MPS_ONT_W-1:0]   output1_on_time_param,
  input  wire [`MPS_ONT_W-1:0]   output2_on_time_param,
  input  wire [`MPS_ONT_W-1:0]   output3_on_time_param,
  input  wire                    gen_busy,
  input  wire                    gen_decel,
  input  wire                    gen_stopped,
  input  wire [`MPS_POS_W-1:0]   gen_remaining,
  input  wire [`MPS_POS_W-1:0]   actual_pos,
  output reg                     move_req,
  output reg                     move_blend,
  output reg                     move_incr,
  output reg  [`MPS_POS_W-1:0]   move_target,
  output reg  [23:0]             move_speed,
  output reg  [23:0]             move_acc,
  output reg  [23:0]             move_dec,
  output reg  [23:0]             move_scurve,
  output reg                     speed_upd,
  output reg                     itp_req,
  output reg  [`MPS_POS_W-1:0]   itp_dist,
  output reg  [2:0]              prog_out,
  output reg  [`MPS_POS_W-1:0]   latch_pos,
  output reg                     running,
  output reg                     prog_error
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] start_sync_reg;
  reg [1:0] latch_sync_reg;
  reg       start_prev_reg;
  reg       latch_prev_reg;
  always @(posedge clk)
  begin
    start_sync_reg <= {start_sync_reg[0], start_pin};
    latch_sync_reg <= {latch_sync_reg[0], latch_pin};
    start_prev_reg <= start_sync_reg[1];
    latch_prev_reg <= latch_sync_reg[1];
  end
  wire start_rise = start_sync_reg[1] & ~start_prev_reg;
  wire latch_rise = latch_sync_reg[1] & ~latch_prev_reg;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Power-of-ten scaling; unit codes above 3 are not offered
  function [`MPS_POS_W-1:0] scale_pos;
    input [23:0] arg;
    input [1:0]  unit_exponent;
    reg   [`MPS_POS_W-1:0] ext;
    begin
      ext = {{(`MPS_POS_W-24){arg[23]}}, arg};
      case (unit_exponent)
        2'h1:    scale_pos = ext * 10;
        2'h2:    scale_pos = ext * 100;
        2'h3:    scale_pos = ext * 1000;
        default: scale_pos = ext;
      endcase
    end
  endfunction

  function [1:0] family_of;
    input [3:0] op;
    begin
      case (op)
        `MPS_OP_ABS, `MPS_OP_ABS_CONT: family_of = `MPS_FAM_ABS;
        `MPS_OP_INC, `MPS_OP_INC_CONT: family_of = `MPS_FAM_INC;
        default:                       family_of = `MPS_FAM_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Program store
  // ----------------------------------------------------------------
  reg  [`MPS_ADDR_W-1:0] pc_reg;
  wire [31:0]            step_word;
  mps_prog_mem mps_prog_mem_i
  (
    .clk     (clk),
    .wr_en   (load_en & ~running),
    .wr_addr (load_addr),
    .wr_data (load_data),
    .rd_addr (pc_reg),
    .rd_data (step_word)
  );
  wire [3:0]  op  = step_word[`MPS_OP_HI:`MPS_OP_LO];
  wire [23:0] arg = step_word[`MPS_ARG_HI:`MPS_ARG_LO];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 3'h0;
  localparam ST_FETCH = 3'h1;
  localparam ST_EXEC  = 3'h2;
  localparam ST_WAIT  = 3'h3;
  localparam ST_TRIP  = 3'h4;
  localparam ST_HOLD  = 3'h5;

  reg [2:0]              state_reg;
  reg [23:0]             speed_reg;
  reg [23:0]             acc_reg;
  reg [23:0]             dec_reg;
  reg [23:0]             scurve_reg;
  reg [1:0]              family_reg;
  reg                    in_motion_reg;
  reg [`MPS_POS_W-1:0]   trip_reg;
  reg [`MPS_POS_W-1:0]   trip_start_reg;
  reg [`MPS_TICK_W-1:0]  tick_cnt_reg;
  reg [`MPS_ONT_W-1:0]   hold_cnt_reg;
  wire tick = (tick_cnt_reg == `MPS_TICK_LAST);
  wire [`MPS_POS_W-1:0] travelled = actual_pos - trip_start_reg;
  wire [`MPS_POS_W-1:0] varg = scale_pos(arg, position_unit_param); // R07

  // On-time of the output addressed by arg[1:0]; zero on-time means no hold
  reg [`MPS_ONT_W-1:0] on_time;
  always @*
  begin
    case (arg[1:0])
      2'h1:    on_time = output1_on_time_param;
      2'h2:    on_time = output2_on_time_param;
      2'h3:    on_time = output3_on_time_param;
      default: on_time = {`MPS_ONT_W{1'b0}};
    endcase
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      state_reg      <= ST_IDLE;
      pc_reg         <= {`MPS_ADDR_W{1'b0}};
      speed_reg      <= 24'h000000;
      acc_reg        <= 24'h000000;
      dec_reg        <= 24'h000000;
      scurve_reg     <= 24'h000000;
      family_reg     <= `MPS_FAM_NONE;
      in_motion_reg  <= 1'b0;
      trip_reg       <= {`MPS_POS_W{1'b0}};
      trip_start_reg <= {`MPS_POS_W{1'b0}};
      tick_cnt_reg   <= {`MPS_TICK_W{1'b0}};
      hold_cnt_reg   <= {`MPS_ONT_W{1'b0}};
      move_req       <= 1'b0;
      move_blend     <= 1'b0;
      move_incr      <= 1'b0;
      move_target    <= {`MPS_POS_W{1'b0}};
      move_speed     <= 24'h000000;
      move_acc       <= 24'h000000;
      move_dec       <= 24'h000000;
      move_scurve    <= 24'h000000;
      speed_upd      <= 1'b0;
      itp_req        <= 1'b0;
      itp_dist       <= {`MPS_POS_W{1'b0}};
      prog_out       <= 3'h0;
      latch_pos      <= {`MPS_POS_W{1'b0}};
      running        <= 1'b0;
      prog_error     <= 1'b0;
    end
    else
    begin
      move_req  <= 1'b0;
      speed_upd <= 1'b0;
      itp_req   <= 1'b0;
      tick_cnt_reg <= tick ? {`MPS_TICK_W{1'b0}} : tick_cnt_reg + 1'b1;
      case (state_reg)
        ST_IDLE:
        begin
          if (start_rise)
          begin
            pc_reg        <= {`MPS_ADDR_W{1'b0}};
            scurve_reg    <= s_curve_time_param;   // R09 R06
            family_reg    <= `MPS_FAM_NONE;
            in_motion_reg <= 1'b0;
            prog_error    <= 1'b0;
            running       <= 1'b1;
            state_reg     <= ST_FETCH;             // R08
          end
        end
        ST_FETCH:
          state_reg <= ST_EXEC;
        ST_EXEC:
        begin
          pc_reg    <= pc_reg + 1'b1;
          state_reg <= ST_FETCH;
          case (op)
            `MPS_OP_SPEED:
            begin
              speed_reg <= arg;                    // R08
              if (in_motion_reg && gen_busy)
              begin
                move_speed <= arg;                 // R02
                speed_upd  <= 1'b1;
              end
            end
            `MPS_OP_ACC:    acc_reg    <= arg;     // R03 R08
            `MPS_OP_DEC:    dec_reg    <= arg;     // R03 R08
            `MPS_OP_ACCDEC:
            begin
              acc_reg <= arg;                      // R03 R08
              dec_reg <= arg;
            end
            `MPS_OP_SCURVE: scurve_reg <= arg;     // R10 R06
            `MPS_OP_ABS, `MPS_OP_INC:
            begin
              move_req      <= 1'b1;
              move_blend    <= 1'b0;
              move_incr     <= (op == `MPS_OP_INC);
              move_target   <= varg;               // R07
              move_speed    <= speed_reg;
              move_acc      <= acc_reg;            // R03
              move_dec      <= dec_reg;
              move_scurve   <= scurve_reg;         // R10
              family_reg    <= family_of(op);
              in_motion_reg <= 1'b1;
              trip_start_reg <= actual_pos;
              state_reg     <= ST_WAIT;
            end
            `MPS_OP_ABS_CONT, `MPS_OP_INC_CONT:
            begin
              if (family_reg != family_of(op) && family_reg != `MPS_FAM_NONE)
              begin
                prog_error <= 1'b1;                // R16 R11
                running    <= 1'b0;
                prog_out   <= 3'h0;
                state_reg  <= ST_IDLE;
              end
              else
              begin
                // Generator blends from the prior deceleration start point
                move_req    <= 1'b1;
                move_blend  <= 1'b1;               // R12 R13 R14
                move_incr   <= (op == `MPS_OP_INC_CONT);
                move_target <= varg;
                move_speed  <= speed_reg;          // R14
                family_reg  <= family_of(op);
                in_motion_reg <= 1'b1;             // R15: acc/dec held
                trip_start_reg <= actual_pos;
                state_reg   <= ST_WAIT;
              end
            end
            `MPS_OP_OUT_ON:
            begin
              prog_out[arg[1:0] - 2'h1] <= 1'b1;   // R01
              if (on_time != {`MPS_ONT_W{1'b0}})
              begin
                hold_cnt_reg <= on_time;           // R04
                state_reg    <= ST_HOLD;
              end
            end
            `MPS_OP_OUT_OFF: prog_out[arg[1:0] - 2'h1] <= 1'b0; // R01
            `MPS_OP_TRIP:
            begin
              trip_reg  <= varg;                   // R07 R01
              state_reg <= ST_TRIP;
            end
            `MPS_OP_LATCH:
              if (latch_rise)
                latch_pos <= actual_pos;           // R01
              else
              begin
                pc_reg    <= pc_reg;
                state_reg <= ST_EXEC;
              end
            `MPS_OP_ITP:
              if (!(gen_remaining <= varg || gen_stopped || gen_decel))
              begin
                itp_req  <= 1'b1;                  // R05 R01
                itp_dist <= varg;
              end
            `MPS_OP_SYNC: ;                        // R01
            default:
            begin
              running   <= 1'b0;                   // Stop ends outputs too
              prog_out  <= 3'h0;
              state_reg <= ST_IDLE;
            end
          endcase
        end
        ST_WAIT:
          // Immediate steps proceed while the generator runs
          state_reg <= ST_FETCH;                   // R01
        ST_TRIP:
          if (travelled >= trip_reg || trip_reg - travelled > trip_reg)
            state_reg <= ST_FETCH;
        ST_HOLD:
          if (hold_cnt_reg == {`MPS_ONT_W{1'b0}})
            state_reg <= ST_FETCH;                 // R04
          else if (tick)
            hold_cnt_reg <= hold_cnt_reg - 1'b1;
        default:
          state_reg <= ST_IDLE;
      endcase
      if (!gen_busy && state_reg == ST_IDLE)
        in_motion_reg <= 1'b0;
    end
  end

endmodule // mps_sequencer

// ===== bench/mps_seq_chk.sv
// Purpose: Port checker for the program sequencer
// Assumes: One clock, srst synchronous active high
// Notes: Bound to the design top after the module
`timescale 1ns/1ps
module mps_seq_chk
(
  input wire        clk,
  input wire        srst,
  input wire        gen_decel,
  input wire        gen_stopped,
  input wire        move_req,
  input wire        move_blend,
  input wire        move_incr,
  input wire [23:0] move_acc,
  input wire [23:0] move_dec,
  input wire        speed_upd,
  input wire        itp_req,
  input wire [2:0]  prog_out,
  input wire        running,
  input wire        prog_error
);
  // ----------------------------------------------------------
  // Family of the last travel, so a blend can be judged
  // ----------------------------------------------------------
  reg have_prev_reg;
  reg last_incr_reg;
  always @(posedge clk)
  begin
    if (srst || !running)
    begin
      have_prev_reg <= 1'b0;
      last_incr_reg <= 1'b0;
    end
    else if (move_req)
    begin
      have_prev_reg <= 1'b1;
      last_incr_reg <= move_incr;
    end
  end
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_quiet2;
    !move_req ##1 !move_req;
  endsequence
  sequence s_blend_req;
    move_req && move_blend;
  endsequence
  AST_REQ_SPACING: assert property (move_req |=> s_quiet2)
    else $error("move requests closer than three cycles");
  AST_BLEND_TC: assert property (s_blend_req |-> $stable(move_acc) && $stable(move_dec))
    else $error("continuous travel took new time constants");
  AST_BLEND_FAMILY: assert property (s_blend_req ##0 have_prev_reg |-> move_incr == last_incr_reg)
    else $error("continuous travel of the other family issued");
  AST_ERR_HALTS: assert property ($rose(prog_error) |-> !running && prog_out == 3'h0)
    else $error("program error left program or outputs active");
  AST_ERR_NO_MOVE: assert property (prog_error |-> !move_req && !speed_upd)
    else $error("motion issued while in program error");
  AST_SPEED_MID: assert property (speed_upd |-> running && !move_req)
    else $error("speed update outside a running program");
  AST_ITP_MOVING: assert property (itp_req |-> !$past(gen_stopped) && !$past(gen_decel))
    else $error("interrupt step issued while stopped or slowing");
  AST_STOP_CLEARS: assert property ($fell(running) |-> prog_out == 3'h0)
    else $error("program outputs left on after stop");
endmodule // mps_seq_chk

bind mps_sequencer mps_seq_chk mps_seq_chk_i (.clk(clk), .srst(srst), .gen_decel(gen_decel),
  .gen_stopped(gen_stopped), .move_req(move_req), .move_blend(move_blend), .move_incr(move_incr),
  .move_acc(move_acc), .move_dec(move_dec), .speed_upd(speed_upd), .itp_req(itp_req),
  .prog_out(prog_out), .running(running), .prog_error(prog_error));

// ===== bench/mps_gen_model.sv
// Purpose: Position generator model, one unit per cycle
// Assumes: Targets small enough for a short run
// Notes: Interrupt requests are not acted on
`timescale 1ns/1ps
module mps_gen_model
#(
  parameter DECEL_LEN = 16
)
(
  input  wire         clk,
  input  wire         srst,
  input  wire         move_req,
  input  wire         move_incr,
  input  wire [31:0]  move_target,
  output wire         gen_busy,
  output wire         gen_decel,
  output wire         gen_stopped,
  output wire [31:0]  gen_remaining,
  output logic [31:0] actual_pos
);
  logic [31:0] goal_reg;
  wire         up = $signed(goal_reg) > $signed(actual_pos);
  assign gen_remaining = up ? goal_reg - actual_pos : actual_pos - goal_reg;
  assign gen_busy      = gen_remaining != 32'h0;
  assign gen_stopped   = !gen_busy;
  assign gen_decel     = gen_busy && gen_remaining <= DECEL_LEN;
  always @(posedge clk)
  begin
    if (srst)
    begin
      goal_reg   <= 32'h0;
      actual_pos <= 32'h0;
    end
    // A new goal retargets without stopping, so blends run through
    else if (move_req)
      goal_reg <= move_incr ? goal_reg + move_target : move_target;
    else if (gen_busy)
      actual_pos <= up ? actual_pos + 32'h1 : actual_pos - 32'h1;
  end
endmodule // mps_gen_model

// ===== bench/tb_mps_sequencer.sv
// Purpose: Self-checking bench for the program sequencer
// Assumes: 100 MHz clk, inputs driven on the falling edge
// Notes: A 10 ms on-time is too long to wait out; only the hold is seen
`timescale 1ns/1ps
`include "mps_defs.vh"
module tb_mps_sequencer;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        load_en = 1'b0;
  logic [5:0]  load_addr = 6'h0;
  logic [31:0] load_data = 32'h0;
  logic        start_pin = 1'b0;
  logic        latch_pin = 1'b0;
  logic [1:0]  unit = 2'h1;
  logic [15:0] on1 = 16'h0;
  wire         gen_busy, gen_decel, gen_stopped, move_req, move_blend, move_incr, speed_upd, itp_req;
  wire         running, prog_error;
  wire [31:0]  gen_remaining, actual_pos, move_target, itp_dist, latch_pos;
  wire [23:0]  move_speed, move_acc, move_dec, move_scurve;
  wire [2:0]   prog_out;
  int          err_count = 0;
  int          checked = 0;
  int          mc = 0;
  int          n_spd = 0;
  int          n_itp = 0;
  int          n_stop = 0;
  int          s;
  logic        stop_q = 1'b1;
  logic        ib;
  logic [2:0]  io;
  logic [31:0] idist;
  logic        m_bl[0:7];
  logic        m_in[0:7];
  logic [31:0] m_tg[0:7];
  logic [23:0] m_sp[0:7], m_ac[0:7], m_de[0:7], m_sc[0:7];

  always #5 clk = ~clk;

  mps_sequencer mps_sequencer_i (.clk(clk), .srst(srst), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .start_pin(start_pin), .latch_pin(latch_pin), .s_curve_time_param(24'h7),
    .position_unit_param(unit), .output1_on_time_param(on1), .output2_on_time_param(16'h0),
    .output3_on_time_param(16'h0), .gen_busy(gen_busy), .gen_decel(gen_decel), .gen_stopped(gen_stopped),
    .gen_remaining(gen_remaining), .actual_pos(actual_pos), .move_req(move_req), .move_blend(move_blend),
    .move_incr(move_incr), .move_target(move_target), .move_speed(move_speed), .move_acc(move_acc),
    .move_dec(move_dec), .move_scurve(move_scurve), .speed_upd(speed_upd), .itp_req(itp_req),
    .itp_dist(itp_dist), .prog_out(prog_out), .latch_pos(latch_pos), .running(running),
    .prog_error(prog_error));
  mps_gen_model mps_gen_model_i (.clk(clk), .srst(srst), .move_req(move_req), .move_incr(move_incr),
    .move_target(move_target), .gen_busy(gen_busy), .gen_decel(gen_decel), .gen_stopped(gen_stopped),
    .gen_remaining(gen_remaining), .actual_pos(actual_pos));

  // ----------------------------------------------------------
  // Monitor: record the first eight moves and count pulses
  // ----------------------------------------------------------
  always @(posedge clk)
  begin
    if (move_req && mc < 8)
    begin
      m_bl[mc] <= move_blend;
      m_in[mc] <= move_incr;
      m_tg[mc] <= move_target;
      m_sp[mc] <= move_speed;
      m_ac[mc] <= move_acc;
      m_de[mc] <= move_dec;
      m_sc[mc] <= move_scurve;
    end
    if (move_req)
      mc <= mc + 1;
    if (speed_upd)
      n_spd <= n_spd + 1;
    if (itp_req)
    begin
      n_itp <= n_itp + 1;
      ib <= gen_busy;
      io <= prog_out;
      idist <= itp_dist;
    end
    if (gen_stopped && !stop_q)
      n_stop <= n_stop + 1;
    stop_q <= gen_stopped;
  end

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task chk_mv(input int i, input logic bl, inc, input logic [31:0] tg, input logic [23:0] sp, ac, de, sc);
    chk("blend", {31'h0, bl}, {31'h0, m_bl[i]});
    chk("incr", {31'h0, inc}, {31'h0, m_in[i]});
    chk("target", tg, m_tg[i]);
    chk("speed", {8'h0, sp}, {8'h0, m_sp[i]});
    chk("acc", {8'h0, ac}, {8'h0, m_ac[i]});
    chk("dec", {8'h0, de}, {8'h0, m_de[i]});
    chk("scurve", {8'h0, sc}, {8'h0, m_sc[i]});
  endtask

  task ld(input logic [3:0] op, input logic [23:0] arg);
    @(negedge clk);
    load_en = 1'b1;
    load_addr = 6'(s);
    load_data = {op, 4'h0, arg};
    s++;
    @(negedge clk);
    load_en = 1'b0;
  endtask

  task run(input logic to_end);
    int k;
    @(negedge clk);
    start_pin = 1'b1;
    repeat (2) @(negedge clk);
    start_pin = 1'b0;
    for (k = 0; k < 20 && running !== 1'b1; k++) @(negedge clk);
    chk("running", 32'h1, {31'h0, running});
    if (to_end)
    begin
      for (k = 0; k < 20000 && (running !== 1'b0 || gen_stopped !== 1'b1); k++) @(negedge clk);
      @(negedge clk);
      chk("ended", 32'h0, {31'h0, running});
      s = 0;
    end
  endtask

  task summarize;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    summarize();
  end

  // ----------------------------------------------------------
  // Programs
  // ----------------------------------------------------------
  initial
  begin
    s = 0;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    ld(`MPS_OP_SPEED, 24'h64);
    ld(`MPS_OP_ACC, 24'h14);
    ld(`MPS_OP_DEC, 24'h1E);
    ld(`MPS_OP_ABS, 24'h32);
    ld(`MPS_OP_SPEED, 24'hC8);
    ld(`MPS_OP_ACCDEC, 24'h63);
    ld(`MPS_OP_ABS_CONT, 24'h50);
    ld(`MPS_OP_STOP, 24'h0);
    run(1'b1);
    chk("stops", 32'h1, 32'(n_stop));
    chk("speed_upd", 32'h1, {31'h0, n_spd != 0});
    chk_mv(0, 1'b0, 1'b0, 32'h1F4, 24'h64, 24'h14, 24'h1E, 24'h7);
    chk_mv(1, 1'b1, 1'b0, 32'h320, 24'hC8, 24'h14, 24'h1E, 24'h7);
    ld(`MPS_OP_SCURVE, 24'h9);
    ld(`MPS_OP_INC, 24'h1E);
    ld(`MPS_OP_STOP, 24'h0);
    run(1'b1);
    chk_mv(2, 1'b0, 1'b1, 32'h12C, 24'hC8, 24'h63, 24'h63, 24'h9);
    unit = 2'h2;
    ld(`MPS_OP_INC, 24'h1);
    ld(`MPS_OP_INC_CONT, 24'h1);
    ld(`MPS_OP_STOP, 24'h0);
    run(1'b1);
    chk_mv(3, 1'b0, 1'b1, 32'h64, 24'hC8, 24'h63, 24'h63, 24'h7);
    chk_mv(4, 1'b1, 1'b1, 32'h64, 24'hC8, 24'h63, 24'h63, 24'h7);
    unit = 2'h1;
    ld(`MPS_OP_ABS, 24'hC8);
    ld(`MPS_OP_OUT_ON, 24'h2);
    ld(`MPS_OP_ITP, 24'h5);
    ld(`MPS_OP_STOP, 24'h0);
    run(1'b1);
    chk_mv(5, 1'b0, 1'b0, 32'h7D0, 24'hC8, 24'h63, 24'h63, 24'h7);
    chk("itp_busy", 32'h1, {31'h0, ib});
    chk("itp_out", 32'h2, {29'h0, io});
    chk("itp_dist", 32'h32, idist);
    ld(`MPS_OP_ITP, 24'h5);
    ld(`MPS_OP_OUT_ON, 24'h3);
    ld(`MPS_OP_STOP, 24'h0);
    s = 0;
    run(1'b1);
    chk("itp_skip", 32'h1, 32'(n_itp));
    chk("out_off", 32'h0, {29'h0, prog_out});
    ld(`MPS_OP_INC, 24'h14);
    ld(`MPS_OP_TRIP, 24'hA);
    ld(`MPS_OP_OUT_ON, 24'h1);
    ld(`MPS_OP_SYNC, 24'h0);
    ld(`MPS_OP_OUT_OFF, 24'h1);
    ld(`MPS_OP_OUT_ON, 24'h3);
    ld(`MPS_OP_LATCH, 24'h0);
    ld(`MPS_OP_STOP, 24'h0);
    run(1'b0);
    repeat (50) @(negedge clk);
    chk("trip_wait", 32'h0, {29'h0, prog_out});
    repeat (300) @(negedge clk);
    chk("out_sel", 32'h4, {29'h0, prog_out});
    chk("latch_wait", 32'h1, {31'h0, running});
    latch_pin = 1'b1;
    repeat (10) @(negedge clk);
    latch_pin = 1'b0;
    repeat (10) @(negedge clk);
    chk("latch_done", 32'h0, {31'h0, running});
    chk("latch_pos", 32'h898, latch_pos);
    s = 0;
    on1 = 16'h1;
    ld(`MPS_OP_OUT_ON, 24'h1);
    ld(`MPS_OP_STOP, 24'h0);
    run(1'b0);
    repeat (3000) @(negedge clk);
    chk("hold_run", 32'h1, {31'h0, running});
    chk("hold_out", 32'h1, {29'h0, prog_out});
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    on1 = 16'h0;
    s = 0;
    ld(`MPS_OP_ABS, 24'h5);
    ld(`MPS_OP_INC_CONT, 24'h5);
    ld(`MPS_OP_STOP, 24'h0);
    run(1'b1);
    chk("error", 32'h1, {31'h0, prog_error});
    chk("moves", 32'h8, 32'(mc));
    summarize();
  end
endmodule // tb_mps_sequencer
